// file: src/phy_loopback_vt_config.sv
// loopback and vt-inhibit configuration register with avalon-mm slave
// assumes a synchronous avalon-mm master on sys_clk and word addressing by byte offsets
`timescale 1ns/100ps
module phy_loopback_vt_config
  import phy_lb_pkg::*;
#(
  parameter int VT_PERIOD = 16
)
(
  // clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          nrst,
  // avalon-mm slave
  input  wire logic [phy_lb_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [31:0]                   avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [31:0]                   avs_readdata,
  output logic                               avs_waitrequest,
  output logic      [1:0]                    avs_response,
  // phy side
  input  wire logic                          oe_in,
  input  wire logic [7:0]                    vt_measured,
  output logic                               loopback_active,
  output logic                               gate_open,
  output logic                               gate_train_req,
  output logic      [7:0]                    strobe_delay,
  output logic                               lb_after_buf,
  output logic                               lb_path_ok,
  output logic      [7:0]                    vt_comp_value,
  output logic                               comp_calc_inhibit
);
  import phy_lb_pkg::*;

  // ------------------------------------------------------------
  // register state
  // ------------------------------------------------------------
  logic [31:0] cfg1_ff;
  logic [7:0]  dly_ff;
  logic [7:0]  vt_ff;
  logic [$clog2(VT_PERIOD+1)-1:0] vt_cnt_ff;
  logic        wait_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  resp_ff;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic        req;
  wire logic        req_done;
  wire logic        nxt_wait;
  wire logic        hit_cfg;
  wire logic        hit_sts;
  wire logic        hit_dly;
  wire logic        mapped;
  wire logic [31:0] bmask;
  wire logic [31:0] nxt_cfg1;
  wire logic [7:0]  nxt_dly;
  wire logic [31:0] nxt_rdata;
  wire logic [1:0]  nxt_resp;
  wire logic [31:0] status_word;
  wire logic        vt_tick;
  wire logic [$clog2(VT_PERIOD+1)-1:0] nxt_vt_cnt;
  wire logic [7:0]  nxt_vt;
  wire logic        gate_open_w;
  wire logic        train_w;
  wire logic [7:0]  sdly_w;
  wire logic        after_w;
  wire logic        ok_w;

  // taken while waitrequest is high, completed on the edge it is low
  assign req      = (avs_read || avs_write) && wait_ff;
  assign req_done = (avs_read || avs_write) && !wait_ff;
  assign nxt_wait = !req;
  assign hit_cfg  = avs_address == CFG1_OFFSET;
  assign hit_sts  = avs_address == STATUS_OFFSET;
  assign hit_dly  = avs_address == DLY_OFFSET;
  assign mapped   = hit_cfg || hit_sts || hit_dly;
  assign bmask    = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  // only the upper six bits exist; the rest read zero
  assign nxt_cfg1 = (req_done && avs_write && hit_cfg) ?
                    ((cfg1_ff & ~(bmask & CFG1_WMASK)) |
                     (avs_writedata & bmask & CFG1_WMASK)) :
                    cfg1_ff;
  assign nxt_dly  = (req_done && avs_write && hit_dly && avs_byteenable[0]) ?
                    avs_writedata[7:0] : dly_ff;
  assign status_word = {8'h00, vt_ff, strobe_delay, 4'h0,
                        lb_path_ok, lb_after_buf, gate_train_req, gate_open};
  assign nxt_rdata = hit_cfg ? cfg1_ff :
                     hit_sts ? status_word :
                     hit_dly ? {24'h00_0000, dly_ff} : 32'h0000_0000;
  assign vt_tick  = vt_cnt_ff == ($clog2(VT_PERIOD+1))'(VT_PERIOD - 1);
  assign nxt_resp = mapped ? 2'b00 : 2'b11;
  // inhibit freezes both the period counter and the value
  assign nxt_vt_cnt = cfg1_ff[INHIBIT_BIT] ? vt_cnt_ff :
                      vt_tick ? '0 : vt_cnt_ff + 1'b1;
  assign nxt_vt     = (vt_tick && !cfg1_ff[INHIBIT_BIT]) ? vt_measured : vt_ff;

  // ------------------------------------------------------------
  // bus and registers
  // ------------------------------------------------------------
  // writes land on the completion edge, where waitrequest is low
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg1_ff <= CFG1_RESET;
    end
    else
    begin
      cfg1_ff <= nxt_cfg1;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dly_ff <= DLY_RESET;
    end
    else
    begin
      dly_ff <= nxt_dly;
    end
  end

  // waitrequest low for exactly one cycle per transfer
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wait_ff <= 1'b1;
    end
    else
    begin
      wait_ff <= nxt_wait;
    end
  end

  // read data and response latched when taken, held until the next request
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      rdata_ff <= (req && avs_read) ? nxt_rdata : rdata_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      resp_ff <= 2'b00;
    end
    else
    begin
      resp_ff <= req ? nxt_resp : resp_ff;
    end
  end

  // ------------------------------------------------------------
  // vt compensation tracker
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vt_cnt_ff <= '0;
    end
    else
    begin
      vt_cnt_ff <= nxt_vt_cnt;
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      vt_ff <= DLY_RESET;
    end
    else
    begin
      vt_ff <= nxt_vt;
    end
  end

  // ------------------------------------------------------------
  // loopback path
  // ------------------------------------------------------------
  lb_path_ctrl u_path (
    .sys_clk                    (sys_clk),
    .nrst                       (nrst),
    .loopback_active            (cfg1_ff[LB_ACTIVE_BIT]),
    .loopback_strobe_gating_sel (gate_mode_t'(cfg1_ff[LB_GATE_HI:LB_GATE_LO])),
    .loopback_strobe_shift_sel  (cfg1_ff[LB_SHIFT_BIT]),
    .io_loopback_point          (cfg1_ff[IO_LB_BIT]),
    .sw_strobe_delay            (dly_ff),
    .sw_gate_open               (dly_ff[7]),
    .oe_in                      (oe_in),
    .gate_open_ff               (gate_open_w),
    .gate_train_req_ff          (train_w),
    .strobe_delay_ff            (sdly_w),
    .lb_after_buf_ff            (after_w),
    .lb_path_ok_ff              (ok_w)
  );

  assign gate_open         = gate_open_w;
  assign gate_train_req    = train_w;
  assign strobe_delay      = sdly_w;
  assign lb_after_buf      = after_w;
  assign lb_path_ok        = ok_w;
  assign loopback_active   = cfg1_ff[LB_ACTIVE_BIT];
  assign comp_calc_inhibit = cfg1_ff[INHIBIT_BIT];
  assign vt_comp_value     = vt_ff;
  assign avs_readdata      = rdata_ff;
  assign avs_response      = resp_ff;
  assign avs_waitrequest   = wait_ff;
endmodule // phy_loopback_vt_config

// file: src/phy_lb_pkg.sv
// package: register offsets, field positions and codes for the loopback/vt config register
// assumes nothing of its surroundings
package phy_lb_pkg;
  localparam int                 ADDR_W          = 4;
  localparam logic [ADDR_W-1:0]  CFG1_OFFSET     = 4'h0;
  localparam logic [ADDR_W-1:0]  STATUS_OFFSET   = 4'h4;
  localparam logic [ADDR_W-1:0]  DLY_OFFSET      = 4'h8;
  localparam int                 LB_ACTIVE_BIT   = 31;
  localparam int                 LB_GATE_HI      = 30;
  localparam int                 LB_GATE_LO      = 29;
  localparam int                 LB_SHIFT_BIT    = 28;
  localparam int                 IO_LB_BIT       = 27;
  localparam int                 INHIBIT_BIT     = 26;
  localparam logic [31:0]        CFG1_RESET      = 32'h0000_0000;
  localparam logic [31:0]        CFG1_WMASK      = 32'hFC00_0000;
  localparam logic [7:0]         DLY_RESET       = 8'h00;
  localparam logic [7:0]         DLY_ZERO        = 8'h00;
  typedef enum logic [1:0] {
    gate_always_open = 2'b00,
    gate_trained     = 2'b01,
    gate_software    = 2'b10,
    gate_reserved    = 2'b11
  } gate_mode_t;
endpackage

// file: src/lb_path_ctrl.sv
// loopback path decode: strobe gate, strobe delay and loopback point steering
// assumes config bits come straight from registers in the same clock domain
`timescale 1ns/100ps
module lb_path_ctrl
  import phy_lb_pkg::*;
(
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       nrst,
  // configuration
  input  wire logic       loopback_active,
  input  wire gate_mode_t loopback_strobe_gating_sel,
  input  wire logic       loopback_strobe_shift_sel,
  input  wire logic       io_loopback_point,
  input  wire logic [7:0] sw_strobe_delay,
  input  wire logic       sw_gate_open,
  input  wire logic       oe_in,
  // results
  output logic            gate_open_ff,
  output logic            gate_train_req_ff,
  output logic [7:0]      strobe_delay_ff,
  output logic            lb_after_buf_ff,
  output logic            lb_path_ok_ff
);
  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire logic       nxt_gate_open;
  wire logic       nxt_gate_train;
  wire logic [7:0] nxt_strobe_delay;
  wire logic       nxt_path_ok;

  assign nxt_gate_open  = loopback_active ?
                          ((loopback_strobe_gating_sel == gate_always_open) ||
                           ((loopback_strobe_gating_sel == gate_software) && sw_gate_open)) :
                          sw_gate_open;
  assign nxt_gate_train = loopback_active &&
                          (loopback_strobe_gating_sel == gate_trained);
  assign nxt_strobe_delay = (loopback_active && !loopback_strobe_shift_sel) ?
                            DLY_ZERO : sw_strobe_delay;
  // after-buffer loopback needs oe; before-buffer ignores it
  assign nxt_path_ok = loopback_active && (io_loopback_point || oe_in);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      gate_open_ff      <= 1'b0;
      gate_train_req_ff <= 1'b0;
      strobe_delay_ff   <= DLY_RESET;
      lb_after_buf_ff   <= 1'b0;
      lb_path_ok_ff     <= 1'b0;
    end
    else
    begin
      gate_open_ff      <= nxt_gate_open;
      gate_train_req_ff <= nxt_gate_train;
      strobe_delay_ff   <= nxt_strobe_delay;
      lb_after_buf_ff   <= loopback_active && !io_loopback_point;
      lb_path_ok_ff     <= nxt_path_ok;
    end
  end
endmodule // lb_path_ctrl

// file: tb/phy_lb_assertions.sv
// checker: handshake and loopback decode relations at the config block ports
// assumes a bind onto phy_loopback_vt_config, sharing its sys_clk and nrst
`timescale 1ns/100ps
module phy_lb_assertions
  import phy_lb_pkg::*;
(
  // clock, reset and bus
  input wire logic       sys_clk,
  input wire logic       nrst,
  input wire logic [3:0] avs_address,
  input wire logic       avs_read,
  input wire logic       avs_write,
  input wire logic       avs_waitrequest,
  input wire logic [1:0] avs_response,
  // phy side
  input wire logic       loopback_active,
  input wire logic       gate_open,
  input wire logic       gate_train_req,
  input wire logic       lb_after_buf,
  input wire logic       lb_path_ok,
  input wire logic [7:0] vt_comp_value,
  input wire logic       comp_calc_inhibit
);
  wire take  = (avs_read || avs_write) && avs_waitrequest;
  wire wdone = avs_write && !avs_waitrequest;
  wire hit   = avs_address inside {CFG1_OFFSET, STATUS_OFFSET, DLY_OFFSET};
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  property p_ack; take |=> !avs_waitrequest; endproperty
  a_ack: assert property (p_ack) else $error("request not answered");
  property p_idle; !avs_waitrequest |=> avs_waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("ack held too long");
  property p_resp; take |=> avs_response == ($past(hit) ? 2'b00 : 2'b11); endproperty
  a_resp: assert property (p_resp) else $error("wrong response code");
  property p_hold; !$past(wdone) |-> $stable(loopback_active) && $stable(comp_calc_inhibit); endproperty
  a_hold: assert property (p_hold) else $error("config bit moved without write");
  property p_train; gate_train_req |-> $past(loopback_active); endproperty
  a_train: assert property (p_train) else $error("training outside loopback");
  property p_gate; gate_train_req |-> !gate_open; endproperty
  a_gate: assert property (p_gate) else $error("gate open while training");
  property p_before; $past(loopback_active) && !lb_after_buf |-> lb_path_ok; endproperty
  a_before: assert property (p_before) else $error("inner loopback blocked");
  property p_lbonly; lb_path_ok || lb_after_buf |-> $past(loopback_active); endproperty
  a_lbonly: assert property (p_lbonly) else $error("path flags outside loopback");
  property p_freeze; $past(comp_calc_inhibit) |-> $stable(vt_comp_value); endproperty
  a_freeze: assert property (p_freeze) else $error("vt value moved while inhibited");
endmodule // phy_lb_assertions

bind phy_loopback_vt_config phy_lb_assertions u_chk (.sys_clk(sys_clk), .nrst(nrst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
  .loopback_active(loopback_active), .gate_open(gate_open), .gate_train_req(gate_train_req),
  .lb_after_buf(lb_after_buf), .lb_path_ok(lb_path_ok), .vt_comp_value(vt_comp_value),
  .comp_calc_inhibit(comp_calc_inhibit));

// file: tb/phy_loopback_vt_config_test.sv
// bench: config register, loopback decode and vt inhibit over avalon-mm
// assumes phy_lb_pkg and the design are compiled first
`timescale 1ns/100ps
module phy_loopback_vt_config_test;
  import phy_lb_pkg::*;
  typedef struct {logic [31:0] cfg; logic [7:0] dly; logic oe; logic [31:0] st;} row_t;
  logic        sys_clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0, oe_in = 1'b0;
  logic [3:0]  avs_address = 4'h0, avs_byteenable = 4'hF;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, rd;
  logic [7:0]  vt_measured = 8'h5A, d, strobe_delay, vt_comp_value;
  logic [1:0]  avs_response, rsp, g;
  logic        avs_waitrequest, loopback_active, lp, go;
  logic        gate_open, gate_train_req, lb_after_buf, lb_path_ok, comp_calc_inhibit;
  int          failures = 0, n_checks = 0;
  row_t        rows[32];
  phy_loopback_vt_config #(.VT_PERIOD(4)) dut (.*);
  always #20 sys_clk = ~sys_clk;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one transfer, held until waitrequest is sampled low
  task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    avs_write     <= we;
    avs_read      <= !we;
    avs_address   <= a;
    avs_writedata <= wd;
    @(posedge sys_clk);
    while (avs_waitrequest !== 1'b0) @(posedge sys_clk);
    rd = avs_readdata;
    rsp = avs_response;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic results();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // ------------
  // main sequence
  // ------------
  initial
  begin
    for (int j = 0; j < 32; j++)
    begin
      lp = j[4];
      g  = j[3:2];
      d  = j[1] ? 8'hA5 : 8'h3C;
      go = lp ? (g == 2'b00 || (g == 2'b10 && d[7])) : d[7];
      rows[j].cfg = 32'(j) << 27;
      rows[j].dly = d;
      rows[j].oe  = j[2] ^ j[0];
      rows[j].st  = {16'h0000, (lp && !j[1]) ? 8'h00 : d, 4'h0,
                     lp && (j[0] || rows[j].oe), lp && !j[0], lp && g == 2'b01, go};
    end
    repeat (3) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, CFG1_OFFSET, 32'h0000_0000);
    chk("cfg reset", CFG1_RESET, rd);
    foreach (rows[j])
    begin
      oe_in <= rows[j].oe;
      bus(1'b1, CFG1_OFFSET, rows[j].cfg | 32'h0400_0000);
      bus(1'b1, DLY_OFFSET, {24'h00_0000, rows[j].dly});
      bus(1'b1, CFG1_OFFSET, rows[j].cfg);
      bus(1'b0, CFG1_OFFSET, 32'h0000_0000);
      chk("cfg", rows[j].cfg, rd);
      chk("lb port", rows[j].cfg[31], 32'(loopback_active));
      bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
      chk("status", rows[j].st, rd & 32'h0000_FF0F);
      chk("pins", rows[j].st, {16'h0000, strobe_delay, 4'h0, lb_path_ok,
          lb_after_buf, gate_train_req, gate_open});
    end
    bus(1'b1, CFG1_OFFSET, 32'hFFFF_FFFF);
    avs_byteenable <= 4'h7;
    bus(1'b1, CFG1_OFFSET, 32'h0000_0000);
    avs_byteenable <= 4'hF;
    bus(1'b1, 4'hC, 32'h0000_0000);
    bus(1'b0, 4'hC, 32'h0000_0000);
    chk("unmapped data", 32'h0000_0000, rd);
    chk("unmapped resp", 32'h0000_0003, 32'(rsp));
    bus(1'b0, CFG1_OFFSET, 32'h0000_0000);
    chk("cfg mask", CFG1_WMASK, rd);
    bus(1'b1, CFG1_OFFSET, 32'h0000_0000);
    repeat (12) @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("vt free", 32'h0000_005A, 32'(rd[23:16]));
    bus(1'b1, CFG1_OFFSET, 32'h0400_0000);
    vt_measured <= 8'hC3;
    repeat (12) @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("vt held", 32'h0000_005A, 32'(rd[23:16]));
    chk("inhibit pin", 32'h0000_0001, 32'(comp_calc_inhibit));
    chk("vt pin held", 32'h0000_005A, 32'(vt_comp_value));
    bus(1'b1, CFG1_OFFSET, 32'hA800_0000);
    repeat (12) @(posedge sys_clk);
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("vt resumed", 32'h0000_00C3, 32'(rd[23:16]));
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    bus(1'b0, CFG1_OFFSET, 32'h0000_0000);
    chk("cfg rereset", CFG1_RESET, rd);
    bus(1'b0, STATUS_OFFSET, 32'h0000_0000);
    chk("status rereset", 32'h0000_0000, rd & 32'h0000_FF0F);
    results();
  end
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    results();
  end
endmodule // phy_loopback_vt_config_test
